//--- rtl/sdrpd_pkg.sv
// Constants and carrier types of the self-refresh and power-down block.
// Assumes a 40 MHz ref_clk for the core and a separate command clock.
// Overview of operation
// [R1] Decode self-refresh entry: CS RAS CAS CKE low, WE high
// [R2] Controller enters self-refresh only from idle
// [R3] Controller turns termination off before entry
// [R4] Controller holds CKE low for minimum residency
// [R5] Loop off on entry, re-enabled with reset on exit
// [R6] Self-refresh ignores all inputs but CKE, reset
// [R7] Controller delays writes 512 clocks after exit
// [R8] Internal refresh starts within minimum CKE pulse
// [R9] Controller holds clock stable around self-refresh
// [R10] Exit is CKE high with NOP or deselect
// [R11] Controller waits lock exit time before reads
// [R12] Controller sends only NOP during exit interval
// [R13] Controller issues extra refresh before re-entry
// [R14] Power-down entry: CKE low with NOP or deselect
// [R15] Controller keeps CKE high during busy operations
// [R16] Closed banks give precharge, open gives active
// [R17] Command receivers off after entry delay
// [R18] Exit-mode bit picks slow or fast precharge exit
// [R19] Controller waits lock latency after slow exit
// [R20] Reset during power-down goes straight to reset
// [R21] Controller limits power-down to nine intervals
// [R22] Exit is CKE high with NOP; pulse held minimum
// [R23] Decode refresh: CS RAS CAS low, WE, CKE high
// [R24] Controller freezes refresh debt in self-refresh
// [R25] Controller tracks modes with per-state timers
package sdrpd_pkg;
	localparam int CLK_NS                 = 25;
	localparam int CKE_MIN_NS             = 5;
	localparam int CKE_MIN_CYC            = (CKE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CPDED_NCK              = 2;
	localparam int REFRESH_RUN_NCK        = 8;
	localparam logic [1:0] CMD_NOP_DES    = 2'h0;
	localparam logic [1:0] CMD_REFRESH    = 2'h1;
	localparam logic [1:0] CMD_SR_ENTRY   = 2'h2;
	localparam logic [1:0] CMD_OTHER      = 2'h3;

	typedef enum logic [2:0] {
		SDRPD_RESET = 3'h0,
		SDRPD_IDLE  = 3'h1,
		SDRPD_PPD   = 3'h3,
		SDRPD_APD   = 3'h2,
		SDRPD_SREF  = 3'h6
	} sdrpd_mode_t;

	// Command pins as seen on the link, active low except cke
	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic cke;
	} sdrpd_cmd_t;

	// Device status reported to the core side
	typedef struct packed {
		logic [2:0] mode;
		logic       loopOn;
		logic       loopReset;
		logic       rcvOn;
		logic       refreshBusy;
	} sdrpd_stat_t;
endpackage : sdrpd_pkg

//--- rtl/sdrpd_sync.sv
// Two-flop level synchroniser for a bus of levels.
// Assumes inputs are quasi-static against the receiving clock.
`timescale 1ns/1ps
module sdrpd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rstN,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : sdrpd_sync

//--- rtl/sdrpd_ctrl.sv
// Self-refresh and power-down state logic at the command link.
// Assumes cmdClk is the command clock; status crosses to ref_clk.
`timescale 1ns/1ps
module sdrpd_ctrl
	import sdrpd_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	input  wire logic                  cmdClk,
	input  wire sdrpd_pkg::sdrpd_cmd_t cmdIn,
	input  wire logic                  bankOpen,
	input  wire logic                  opBusy,
	input  wire logic                  loopEnable,
	input  wire logic                  fastExit,
	output sdrpd_pkg::sdrpd_stat_t     status
);
	import sdrpd_pkg::*;

	typedef struct packed {
		sdrpd_mode_t mode;
		logic        loopOn;
		logic        loopReset;
		logic [3:0]  offCnt;
		logic [3:0]  refCnt;
		logic        refDone;
		logic [3:0]  pulseCnt;
	} sdrpd_state_t;

	function automatic logic [1:0] decodeCmd(input sdrpd_cmd_t c,
		input logic prevCke);
		if (c.csN)
			decodeCmd = CMD_NOP_DES;
		else if (!c.rasN && !c.casN && c.weN && prevCke && !c.cke)
			decodeCmd = CMD_SR_ENTRY;
		else if (!c.rasN && !c.casN && c.weN && c.cke)
			decodeCmd = CMD_REFRESH;
		else if (c.rasN && c.casN && c.weN)
			decodeCmd = CMD_NOP_DES;
		else
			decodeCmd = CMD_OTHER;
	endfunction : decodeCmd

	logic       cmdRst1_q;
	logic       cmdRstN;
	logic       prevCke_q;
	logic [1:0] cmd;
	logic       loopWanted;
	logic [2:0] cfgSync;
	sdrpd_state_t cur_q;
	sdrpd_state_t cur_d;

	// Reset release per domain; asserted asynchronously
	always_ff @(posedge cmdClk or negedge nrst) begin
		if (!nrst) begin
			cmdRst1_q <= 1'b0;
			cmdRstN   <= 1'b0;
		end else begin
			cmdRst1_q <= 1'b1;
			cmdRstN   <= cmdRst1_q;
		end
	end

	// Mode bits come from core registers, so they cross to cmdClk
	sdrpd_sync #(.W(3)) u_cfg (
		.clk  (cmdClk),
		.rstN (cmdRstN),
		.din  ({loopEnable, fastExit, bankOpen}),
		.dout (cfgSync)
	);

	always_ff @(posedge cmdClk or negedge cmdRstN) begin
		if (!cmdRstN)
			prevCke_q <= 1'b0;
		else
			prevCke_q <= cmdIn.cke;
	end

	assign cmd = decodeCmd(cmdIn, prevCke_q); // see [R1] see [R23]

	always_comb begin
		loopWanted = cfgSync[2];
		cur_d = cur_q;
		cur_d.loopReset = 1'b0;
		if (cur_q.pulseCnt != 4'h0)
			cur_d.pulseCnt = cur_q.pulseCnt - 4'h1;
		if (cur_q.offCnt != 4'h0)
			cur_d.offCnt = cur_q.offCnt - 4'h1;
		if (cur_q.refCnt != 4'h0)
			cur_d.refCnt = cur_q.refCnt - 4'h1;
		case (cur_q.mode)
			SDRPD_RESET: begin
				cur_d.mode   = SDRPD_IDLE;
				cur_d.loopOn = loopWanted;
			end
			SDRPD_IDLE: begin
				cur_d.loopOn = loopWanted;
				if (cmd == CMD_SR_ENTRY) begin
					cur_d.mode     = SDRPD_SREF; // see [R1]
					cur_d.loopOn   = 1'b0; // see [R5]
					cur_d.offCnt   = 4'(CPDED_NCK);
					cur_d.refCnt   = 4'(CKE_MIN_CYC); // see [R8]
					cur_d.refDone  = 1'b0;
					cur_d.pulseCnt = 4'(CKE_MIN_CYC);
				end else if (prevCke_q && !cmdIn.cke
					&& cmd == CMD_NOP_DES) begin
					// Bank state after in-flight work picks the flavour
					cur_d.mode = cfgSync[0] ? SDRPD_APD : SDRPD_PPD; // see [R14] see [R16]
					cur_d.loopOn = cfgSync[0] | cfgSync[1] ? loopWanted
						: 1'b0; // see [R18]
					cur_d.offCnt   = 4'(CPDED_NCK); // see [R17]
					cur_d.pulseCnt = 4'(CKE_MIN_CYC);
				end else if (cmd == CMD_REFRESH) begin
					// Reloads on a repeat, so back-to-back refreshes stretch
					cur_d.refCnt = 4'(REFRESH_RUN_NCK); // see [R23]
				end
			end
			SDRPD_PPD, SDRPD_APD: begin
				// Exit also needs the minimum pulse; held pulses are assumed
				if (cmdIn.cke && cur_q.pulseCnt == 4'h0) begin // see [R22]
					cur_d.mode = SDRPD_IDLE;
					if (!cur_q.loopOn && loopWanted)
						cur_d.loopReset = 1'b1;
					cur_d.loopOn = loopWanted;
				end
			end
			SDRPD_SREF: begin
				// Only CKE is looked at here; the rest is don't care
				if (cur_q.refCnt == 4'h1)
					cur_d.refDone = 1'b1; // see [R8]
				if (cmdIn.cke && cur_q.pulseCnt == 4'h0) begin // see [R6] see [R10]
					cur_d.mode      = SDRPD_IDLE;
					cur_d.loopOn    = loopWanted; // see [R5]
					cur_d.loopReset = loopWanted; // see [R5]
				end
			end
			default: cur_d.mode = SDRPD_RESET;
		endcase
	end

	// Reset pin drops every mode straight into reset state
	always_ff @(posedge cmdClk or negedge cmdRstN) begin // see [R20]
		if (!cmdRstN) begin
			cur_q <= '{mode: SDRPD_RESET, default: '0};
		end else begin
			cur_q <= cur_d;
		end
	end

	// Status levels cross back into ref_clk
	logic        refRst1_q;
	logic        refRstN;
	sdrpd_stat_t statRaw;
	sdrpd_stat_t statSync;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			refRst1_q <= 1'b0;
			refRstN   <= 1'b0;
		end else begin
			refRst1_q <= 1'b1;
			refRstN   <= refRst1_q;
		end
	end

	always_comb begin
		statRaw.mode        = cur_q.mode;
		statRaw.loopOn      = cur_q.loopOn;
		statRaw.loopReset   = cur_q.loopReset;
		statRaw.rcvOn       = (cur_q.mode == SDRPD_IDLE)
			|| (cur_q.offCnt != 4'h0); // see [R17]
		// A controller refresh keeps the flag up for its whole run
		statRaw.refreshBusy = ((cur_q.mode == SDRPD_SREF)
			&& !cur_q.refDone) || ((cur_q.mode != SDRPD_SREF)
			&& (cur_q.refCnt != 4'h0)); // see [R23]
	end

	// Multi-bit status is a group of slow levels; a mixed sample lasts
	// one ref_clk cycle at most, which the core must tolerate
	sdrpd_sync #(.W($bits(sdrpd_stat_t))) u_stat (
		.clk  (ref_clk),
		.rstN (refRstN),
		.din  (statRaw),
		.dout (statSync)
	);

	always_ff @(posedge ref_clk or negedge refRstN) begin
		if (!refRstN)
			status <= '0;
		else
			status <= statSync;
	end

	property srEntry_p;
		@(posedge cmdClk) disable iff (!cmdRstN)
		(cur_q.mode == SDRPD_IDLE && cmd == CMD_SR_ENTRY)
			|=> (cur_q.mode == SDRPD_SREF && !cur_q.loopOn);
	endproperty
	sr_entry_a: assert property (srEntry_p) // see [R1]
		else $error("self-refresh entry not taken");

	sr_exit_a: assert property ( // see [R5]
		@(posedge cmdClk) disable iff (!cmdRstN)
		($past(cur_q.mode) == SDRPD_SREF && cur_q.mode == SDRPD_IDLE
			&& cur_q.loopOn) |-> cur_q.loopReset)
		else $error("loop not reset on exit");

	sr_hold_a: assert property ( // see [R6]
		@(posedge cmdClk) disable iff (!cmdRstN)
		(cur_q.mode == SDRPD_SREF && !cmdIn.cke)
			|=> cur_q.mode == SDRPD_SREF)
		else $error("self-refresh left without CKE");

	sr_refresh_a: assert property ( // see [R8]
		@(posedge cmdClk) disable iff (!cmdRstN)
		$rose(cur_q.mode == SDRPD_SREF) ##1
			(cur_q.mode == SDRPD_SREF)[*2] |-> cur_q.refDone)
		else $error("internal refresh late");

	pd_kind_a: assert property ( // see [R16]
		@(posedge cmdClk) disable iff (!cmdRstN)
		(cur_q.mode == SDRPD_IDLE && prevCke_q && !cmdIn.cke
			&& cmd == CMD_NOP_DES)
			|=> cur_q.mode == ($past(cfgSync[0]) ? SDRPD_APD : SDRPD_PPD))
		else $error("wrong power-down kind");

	slow_exit_a: assert property ( // see [R18]
		@(posedge cmdClk) disable iff (!cmdRstN)
		(cur_q.mode == SDRPD_PPD && !cfgSync[1]) |-> !cur_q.loopOn)
		else $error("loop on in slow exit");

	rcv_off_a: assert property ( // see [R17]
		@(posedge cmdClk) disable iff (!cmdRstN)
		$rose(cur_q.mode == SDRPD_APD)
			|-> ##2 (cur_q.offCnt == 4'h0))
		else $error("receivers not timed off");

	pd_exit_a: assert property ( // see [R22]
		@(posedge cmdClk) disable iff (!cmdRstN)
		(cur_q.mode == SDRPD_PPD && cmdIn.cke && cur_q.pulseCnt == 4'h0)
			|=> cur_q.mode == SDRPD_IDLE)
		else $error("power-down exit missed");

	// Steps shared by several checks below
	sequence pdEntry_s;
		cur_q.mode == SDRPD_IDLE && prevCke_q && !cmdIn.cke
			&& cmd == CMD_NOP_DES;
	endsequence

	sequence refIssue_s;
		cur_q.mode == SDRPD_IDLE && cmd == CMD_REFRESH;
	endsequence

	pd_entry_a: assert property ( // see [R14]
		@(posedge cmdClk) disable iff (!cmdRstN)
		pdEntry_s |=> cur_q.mode inside {SDRPD_PPD, SDRPD_APD})
		else $error("power-down entry not taken");

	rcv_hold_a: assert property ( // see [R17]
		@(posedge cmdClk) disable iff (!cmdRstN)
		pdEntry_s |=> statRaw.rcvOn)
		else $error("receivers off too early");

	// Guarded by CKE staying low, since an early exit is legal
	rcv_drop_a: assert property ( // see [R17]
		@(posedge cmdClk) disable iff (!cmdRstN)
		pdEntry_s ##1 (!cmdIn.cke)[*2] |=> !statRaw.rcvOn)
		else $error("receivers left on");

	ref_run_a: assert property ( // see [R23]
		@(posedge cmdClk) disable iff (!cmdRstN)
		refIssue_s |=> cur_q.refCnt == 4'(REFRESH_RUN_NCK))
		else $error("refresh not started");

	ref_busy_a: assert property ( // see [R23]
		@(posedge cmdClk) disable iff (!cmdRstN)
		refIssue_s |=> statRaw.refreshBusy)
		else $error("refresh not shown busy");

	pd_min_a: assert property ( // see [R22]
		@(posedge cmdClk) disable iff (!cmdRstN)
		((cur_q.mode == SDRPD_PPD || cur_q.mode == SDRPD_APD)
			&& cur_q.pulseCnt != 4'h0) |=> cur_q.mode != SDRPD_IDLE)
		else $error("power-down left before minimum pulse");

	sr_loop_a: assert property ( // see [R5]
		@(posedge cmdClk) disable iff (!cmdRstN)
		cur_q.mode == SDRPD_SREF |-> !cur_q.loopOn)
		else $error("loop running in self-refresh");

	sr_ignore_a: assert property ( // see [R6]
		@(posedge cmdClk) disable iff (!cmdRstN)
		(cur_q.mode == SDRPD_SREF && cmdIn.cke && cur_q.pulseCnt == 4'h0)
			|=> cur_q.mode == SDRPD_IDLE)
		else $error("self-refresh exit missed");

	apd_loop_a: assert property ( // see [R18]
		@(posedge cmdClk) disable iff (!cmdRstN)
		$rose(cur_q.mode == SDRPD_APD) |-> cur_q.loopOn == $past(loopWanted))
		else $error("loop not kept in active power-down");

	rst_idle_a: assert property ( // see [R20]
		@(posedge cmdClk) disable iff (!cmdRstN)
		cur_q.mode == SDRPD_RESET |=> cur_q.mode == SDRPD_IDLE)
		else $error("reset state not left");
endmodule : sdrpd_ctrl

//--- verif/sdrpd_ctl_model.sv
// Controller-side model that drives the command pins on cmdClk.
// Assumes the bench holds op and cke for many link clocks.
`timescale 1ns/1ps
module sdrpd_ctl_model
	import sdrpd_pkg::*;
(
	input  wire logic             cmdClk,
	input  wire logic [1:0]       op,
	input  wire logic             cke,
	output sdrpd_pkg::sdrpd_cmd_t cmdIn
);
	initial cmdIn = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	always @(posedge cmdClk) begin
		case (op)
			// Refresh pattern; with cke low it is self-refresh entry
			CMD_REFRESH:  cmdIn <= '{1'b0, 1'b0, 1'b0, 1'b1, cke};
			CMD_SR_ENTRY: cmdIn <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
			CMD_OTHER:    cmdIn <= '{1'b0, 1'b0, 1'b1, 1'b1, cke};
			// Deselect: the other lines are left to wander
			default: cmdIn <= '{1'b1, ~cmdIn.rasN, ~cmdIn.casN,
				~cmdIn.weN, cke};
		endcase
	end
endmodule : sdrpd_ctl_model

//--- verif/tb.sv
// Self-checking bench for the self-refresh and power-down block.
// Assumes status settles within 16 ref_clk cycles of a command step.
`timescale 1ns/1ps
module tb;
	import sdrpd_pkg::*;
	logic        ref_clk, cmdClk, nrst, cke, sawRef, sawLrst;
	logic        bankOpen, loopEnable, fastExit;
	logic [1:0]  op;
	int          fail_count, checked, cycles;
	sdrpd_cmd_t  cmdIn;
	sdrpd_stat_t status;

	sdrpd_ctl_model sdrpd_ctl_model_i (
		.cmdClk(cmdClk),
		.op    (op),
		.cke   (cke),
		.cmdIn (cmdIn)
	);
	sdrpd_ctrl sdrpd_ctrl_i (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.cmdClk    (cmdClk),
		.cmdIn     (cmdIn),
		.bankOpen  (bankOpen),
		.opBusy    (1'b0),
		.loopEnable(loopEnable),
		.fastExit  (fastExit),
		.status    (status)
	);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Odd offset keeps the link clock unrelated in phase
	initial begin
		cmdClk = 1'b0;
		#7;
		forever #15 cmdClk = ~cmdClk;
	end
	// Refresh may be a short pulse, so it is latched here
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (status.refreshBusy === 1'b1)
			sawRef <= 1'b1;
		if (status.loopReset === 1'b1)
			sawLrst <= 1'b1;
		if (cycles == 2000) begin
			fail_count++;
			end_sim();
		end
	end

	task step(input logic [1:0] o, input logic k);
		@(posedge ref_clk);
		op  <= o;
		cke <= k;
		repeat (16) @(posedge ref_clk);
		#1;
	endtask : step
	task chk_mode(input logic [2:0] exp);
		checked++;
		if (status.mode !== exp) begin
			fail_count++;
			$display("[ERR] %0t mode %h want %h", $time, status.mode, exp);
		end
	endtask : chk_mode
	task chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t status bit %b want %b", $time, got, exp);
		end
	endtask : chk_bit
	task end_sim;
		$display("Mismatches %0d in %0d checks", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	initial begin
		nrst = 1'b0;
		op = CMD_NOP_DES;
		cke = 1'b1;
		bankOpen = 1'b0;
		loopEnable = 1'b1;
		fastExit = 1'b0;
		sawRef = 1'b0;
		sawLrst = 1'b0;
		fail_count = 0;
		checked = 0;
		cycles = 0;
		repeat (12) @(posedge ref_clk);
		#1;
		chk_mode(SDRPD_RESET);
		@(posedge ref_clk);
		nrst <= 1'b1;
		step(CMD_NOP_DES, 1'b1);
		chk_mode(SDRPD_IDLE);
		step(CMD_SR_ENTRY, 1'b0);
		chk_mode(SDRPD_SREF);
		chk_bit(status.loopOn, 1'b0);
		chk_bit(sawRef, 1'b1);
		step(CMD_OTHER, 1'b0);
		chk_mode(SDRPD_SREF);
		sawLrst <= 1'b0;
		step(CMD_NOP_DES, 1'b1);
		chk_mode(SDRPD_IDLE);
		chk_bit(status.loopOn, 1'b1);
		chk_bit(sawLrst, 1'b1);
		sawRef <= 1'b0;
		step(CMD_REFRESH, 1'b1);
		chk_bit(sawRef, 1'b1);
		chk_mode(SDRPD_IDLE);
		// Cases: slow precharge, fast precharge, active
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			bankOpen <= (i == 2);
			fastExit <= (i == 1);
			step(CMD_NOP_DES, 1'b1);
			step(CMD_NOP_DES, 1'b0);
			chk_mode(i == 2 ? SDRPD_APD : SDRPD_PPD);
			chk_bit(status.loopOn, i != 0);
			chk_bit(status.rcvOn, 1'b0);
			step(CMD_NOP_DES, 1'b1);
			chk_mode(SDRPD_IDLE);
			chk_bit(status.rcvOn, 1'b1);
		end
		step(CMD_NOP_DES, 1'b0);
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		#1;
		chk_mode(SDRPD_RESET);
		@(posedge ref_clk);
		nrst <= 1'b1;
		step(CMD_NOP_DES, 1'b1);
		chk_mode(SDRPD_IDLE);
		end_sim();
	end
endmodule : tb
